// ### hw/scc_synth_ctrl.sv
// Synthesizer channel control: register file, frequency word, calibration and lock sequencing
// Summary of operation
// - With a double-rate reference the sequencer advances on every second clock only; registers, bus and centre word run every clock.
// - Unless calibration is disabled, a calibration runs on each lock need: ready to lock/rx/tx and rx/tx swaps.
// - At calibration end the result word is applied and written into the matching calibration register.
// - With calibration disabled, the stored rx or tx word is applied directly and lock follows sooner.
// - Centre frequency is base plus channel index times step, step being fxo/2^15 times the step word.
// - Base frequency is fxo over (B/2 times D) times the synth word over 2^20.
// - The synth word is 28 bits held in four consecutive byte registers.
// - Band select 0 gives divide by 4, 1 gives divide by 8.
// - Reference halving 0 gives divider 1, 1 gives divider 2.
// - The channel index is one 8-bit register, and writing it alone retunes the synthesizer.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module scc_synth_ctrl #(
  parameter int CAL_W = 7
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [CAL_W-1:0] cal_result_i,
  output logic [31:0] centre_freq_o,
  output logic [CAL_W-1:0] cal_word_o,
  output logic [2:0] charge_pump_current_sel_o,
  output logic phase_detector_split_enable_o,
  output logic band_divider_select_o,
  output logic reference_halving_o,
  output logic synth_locked_o,
  output logic cal_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus capture
  logic [7:0] synth_word_top_register;
  logic [7:0] synth_b2;
  logic [7:0] synth_b1;
  logic [7:0] synth_b0;
  logic [7:0] channel_step_word;
  logic [7:0] channel_index;
  logic [1:0] oscillator_config_register;
  logic synth_config_second_register;
  logic [1:0] target_mode;
  logic cal_disable;
  logic [CAL_W-1:0] cal_rx;
  logic [CAL_W-1:0] cal_tx;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic tick;
  logic half_phase;
  logic [1:0] applied_mode;
  scc_pkg::scc_seq_t seq;
  logic [15:0] seq_cnt;
  logic hw_cal_wr;
  logic hw_cal_tx;
  logic [CAL_W-1:0] cal_sync1;
  logic [CAL_W-1:0] cal_sync2;
  logic [27:0] synth_base_word;
  logic [31:0] next_centre;
  logic [31:0] rd_value;
  logic need_lock;
  logic wr_now;

  assign synth_base_word = {synth_word_top_register[scc_pkg::TOP_WORD_LSB +: 4], synth_b2, synth_b1, synth_b0};
  assign wr_now = wr_pend && ce_i;

  // Read mux sampled by the address phase capture; address decode in one place
  function automatic logic [31:0] read_reg(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      scc_pkg::OFF_SYNTH_TOP: r = {24'h00_0000, synth_word_top_register};
      scc_pkg::OFF_SYNTH_B2: r = {24'h00_0000, synth_b2};
      scc_pkg::OFF_SYNTH_B1: r = {24'h00_0000, synth_b1};
      scc_pkg::OFF_SYNTH_B0: r = {24'h00_0000, synth_b0};
      scc_pkg::OFF_CHAN_STEP: r = {24'h00_0000, channel_step_word};
      scc_pkg::OFF_CHAN_INDEX: r = {24'h00_0000, channel_index};
      scc_pkg::OFF_OSC_CFG: r = {30'h0000_0000, oscillator_config_register};
      scc_pkg::OFF_SYNTH_CFG2: r = {31'h0000_0000, synth_config_second_register};
      scc_pkg::OFF_MODE_CTRL: r = {29'h0000_0000, cal_disable, target_mode};
      scc_pkg::OFF_CAL_RX: r = {{(32-CAL_W){1'b0}}, cal_rx};
      scc_pkg::OFF_CAL_TX: r = {{(32-CAL_W){1'b0}}, cal_tx};
      scc_pkg::OFF_STATUS: r = {26'h000_0000, applied_mode, seq, synth_locked_o, cal_busy_o};
      scc_pkg::OFF_CENTRE: r = centre_freq_o;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Procedural so that it follows the registers the function reads, not only the address
  always_comb begin
    rd_value = read_reg(haddr_i[7:0]);
  end

  // Address phase capture; zero wait states, so reads are sampled at the address phase
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
      wr_addr <= haddr_i[7:0];
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
        hrdata_o <= (haddr_i[31:8] == 24'h00_0000) ? rd_value : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration writes in the data phase
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      synth_word_top_register <= scc_pkg::RST_SYNTH_TOP;
      synth_b2 <= scc_pkg::RST_BYTE;
      synth_b1 <= scc_pkg::RST_BYTE;
      synth_b0 <= scc_pkg::RST_BYTE;
      channel_step_word <= scc_pkg::RST_CHAN_STEP;
      channel_index <= scc_pkg::RST_BYTE;
      oscillator_config_register <= 2'h0;
      synth_config_second_register <= 1'b0;
      target_mode <= scc_pkg::MODE_READY;
      cal_disable <= 1'b0;
    end else if (wr_now) begin
      unique case (wr_addr)
        scc_pkg::OFF_SYNTH_TOP: synth_word_top_register <= hwdata_i[7:0];
        scc_pkg::OFF_SYNTH_B2: synth_b2 <= hwdata_i[7:0];
        scc_pkg::OFF_SYNTH_B1: synth_b1 <= hwdata_i[7:0];
        scc_pkg::OFF_SYNTH_B0: synth_b0 <= hwdata_i[7:0];
        scc_pkg::OFF_CHAN_STEP: channel_step_word <= hwdata_i[7:0];
        scc_pkg::OFF_CHAN_INDEX: channel_index <= hwdata_i[7:0];
        scc_pkg::OFF_OSC_CFG: oscillator_config_register <= hwdata_i[1:0];
        scc_pkg::OFF_SYNTH_CFG2: synth_config_second_register <= hwdata_i[scc_pkg::CFG2_SPLIT_BIT];
        scc_pkg::OFF_MODE_CTRL: begin
          target_mode <= hwdata_i[scc_pkg::CTRL_MODE_LSB +: 2];
          cal_disable <= hwdata_i[scc_pkg::CTRL_CALDIS_BIT];
        end
        default: ;
      endcase
    end
  end

  // Calibration words: the engine's write wins over a software write in the same cycle.
  // The engine stores the word it applied, not a later sample of the asynchronous result.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cal_rx <= '0;
      cal_tx <= '0;
    end else if (ce_i) begin
      if (hw_cal_wr && !hw_cal_tx) begin
        cal_rx <= cal_word_o;
      end else if (wr_pend && wr_addr == scc_pkg::OFF_CAL_RX) begin
        cal_rx <= hwdata_i[CAL_W-1:0];
      end
      if (hw_cal_wr && hw_cal_tx) begin
        cal_tx <= cal_word_o;
      end else if (wr_pend && wr_addr == scc_pkg::OFF_CAL_TX) begin
        cal_tx <= hwdata_i[CAL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital tick: double-rate references run the sequencer at half speed
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      half_phase <= 1'b0;
    end else if (ce_i) begin
      half_phase <= oscillator_config_register[scc_pkg::OSC_DOUBLE_BIT] ? ~half_phase : 1'b0;
    end
  end
  assign tick = ce_i && (!oscillator_config_register[scc_pkg::OSC_DOUBLE_BIT] || half_phase);

  // Analog calibration result crosses in through two flops
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cal_sync1 <= '0;
      cal_sync2 <= '0;
    end else if (ce_i) begin
      cal_sync1 <= cal_result_i;
      cal_sync2 <= cal_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock need: leaving ready, or swapping between receive and transmit
  assign need_lock = (target_mode != scc_pkg::MODE_READY) &&
    ((applied_mode == scc_pkg::MODE_READY) ||
     (applied_mode == scc_pkg::MODE_RX && target_mode == scc_pkg::MODE_TX) ||
     (applied_mode == scc_pkg::MODE_TX && target_mode == scc_pkg::MODE_RX));

  // Sequencer: calibrate, then settle, then report lock
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      seq <= scc_pkg::SQ_IDLE;
      seq_cnt <= 16'h0000;
      applied_mode <= scc_pkg::MODE_READY;
      hw_cal_wr <= 1'b0;
      hw_cal_tx <= 1'b0;
      cal_word_o <= '0;
      synth_locked_o <= 1'b0;
      cal_busy_o <= 1'b0;
    end else if (tick) begin
      hw_cal_wr <= 1'b0;
      if (target_mode == scc_pkg::MODE_READY) begin
        seq <= scc_pkg::SQ_IDLE;
        applied_mode <= scc_pkg::MODE_READY;
        synth_locked_o <= 1'b0;
        cal_busy_o <= 1'b0;
      end else if (need_lock) begin
        applied_mode <= target_mode;
        hw_cal_tx <= (target_mode != scc_pkg::MODE_RX);
        synth_locked_o <= 1'b0;
        if (!cal_disable) begin
          seq <= scc_pkg::SQ_CAL;
          seq_cnt <= 16'(scc_pkg::CAL_CYCLES - 1);
          cal_busy_o <= 1'b1;
        end else begin
          seq <= scc_pkg::SQ_SETTLE;
          seq_cnt <= 16'(scc_pkg::LOCK_CYCLES - 1);
          cal_busy_o <= 1'b0;
          cal_word_o <= (target_mode == scc_pkg::MODE_RX) ? cal_rx : cal_tx;
        end
      end else begin
        applied_mode <= target_mode;
        unique case (seq)
          scc_pkg::SQ_CAL: begin
            if (seq_cnt == 16'h0000) begin
              cal_word_o <= cal_sync2;
              hw_cal_wr <= 1'b1;
              cal_busy_o <= 1'b0;
              seq <= scc_pkg::SQ_SETTLE;
              seq_cnt <= 16'(scc_pkg::LOCK_CYCLES - 1);
            end else begin
              seq_cnt <= seq_cnt - 16'h0001;
            end
          end
          scc_pkg::SQ_SETTLE: begin
            if (seq_cnt == 16'h0000) begin
              seq <= scc_pkg::SQ_LOCKED;
              synth_locked_o <= 1'b1;
            end else begin
              seq_cnt <= seq_cnt - 16'h0001;
            end
          end
          scc_pkg::SQ_IDLE, scc_pkg::SQ_LOCKED: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Centre frequency word in units of fxo/2^23; B/2*D of 2, 4 or 8 is a shift
  always_comb begin
    next_centre = 32'(synth_base_word) << 2;
    if (synth_word_top_register[scc_pkg::TOP_BAND_BIT]) begin
      next_centre = next_centre >> 1;
    end
    if (oscillator_config_register[scc_pkg::OSC_HALVE_BIT]) begin
      next_centre = next_centre >> 1;
    end
    next_centre = next_centre + ((32'(channel_step_word) * 32'(channel_index)) << scc_pkg::CHAN_SHIFT);
  end

  // Analog-facing fields, registered; channel index alone is enough to retune
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      centre_freq_o <= 32'h0000_0000;
      charge_pump_current_sel_o <= 3'h0;
      phase_detector_split_enable_o <= 1'b0;
      band_divider_select_o <= 1'b0;
      reference_halving_o <= 1'b0;
    end else if (ce_i) begin
      centre_freq_o <= next_centre;
      charge_pump_current_sel_o <= synth_word_top_register[scc_pkg::TOP_CP_LSB +: 3];
      phase_detector_split_enable_o <= synth_config_second_register;
      band_divider_select_o <= synth_word_top_register[scc_pkg::TOP_BAND_BIT];
      reference_halving_o <= oscillator_config_register[scc_pkg::OSC_HALVE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_cal_on_lock: assert property (@(posedge mclk_i) disable iff (reset_i)
    (tick && need_lock && !cal_disable) |=> (seq == scc_pkg::SQ_CAL && cal_busy_o))
    else $error("calibration did not start on lock need");
  chk_nocal_settle: assert property (@(posedge mclk_i) disable iff (reset_i)
    (tick && need_lock && cal_disable && target_mode == scc_pkg::MODE_RX) |=> (seq == scc_pkg::SQ_SETTLE
    && cal_word_o == $past(cal_rx)))
    else $error("stored rx word not applied");
  chk_cal_store: assert property (@(posedge mclk_i) disable iff (reset_i)
    (hw_cal_wr && ce_i && hw_cal_tx) |=> (cal_tx == $past(cal_word_o)))
    else $error("calibration result not stored");
  chk_cal_apply: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(cal_busy_o) && hw_cal_wr && seq == scc_pkg::SQ_SETTLE |-> (cal_word_o == $past(cal_sync2)))
    else $error("calibration result not applied");
  chk_half_tick: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && oscillator_config_register[scc_pkg::OSC_DOUBLE_BIT] && tick) |=> !tick)
    else $error("double rate ticks on consecutive cycles");
  chk_centre_word: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && synth_word_top_register[scc_pkg::TOP_BAND_BIT] == 1'b0 && !oscillator_config_register[0])
    |=> centre_freq_o == $past(32'(synth_base_word) * 32'h4 + 32'(channel_step_word) * 32'(channel_index) * 32'h100))
    else $error("centre word mismatch");
  chk_band_div8: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && synth_word_top_register[scc_pkg::TOP_BAND_BIT] && oscillator_config_register[0])
    |=> centre_freq_o == $past(32'(synth_base_word) + 32'(channel_step_word) * 32'(channel_index) * 32'h100))
    else $error("divide by 8 with halving mismatch");
  chk_ready_unlock: assert property (@(posedge mclk_i) disable iff (reset_i)
    (tick && target_mode == scc_pkg::MODE_READY) |=> !synth_locked_o && !cal_busy_o)
    else $error("lock held in ready");
  chk_lock_after: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(synth_locked_o) |-> $past(seq) == scc_pkg::SQ_SETTLE)
    else $error("lock without settle");
  cov_cal_lock: cover property (@(posedge mclk_i) disable iff (reset_i) $fell(cal_busy_o));
  cov_stored_lock: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(synth_locked_o) && cal_disable);
  cov_rx_tx_swap: cover property (@(posedge mclk_i) disable iff (reset_i)
    tick && need_lock && applied_mode == scc_pkg::MODE_RX);

endmodule // scc_synth_ctrl

// ### shared/scc_pkg.sv
// Shared constants for the synthesizer channel control block
package scc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_SYNTH_TOP = 8'h00;
  localparam logic [7:0] OFF_SYNTH_B2 = 8'h04;
  localparam logic [7:0] OFF_SYNTH_B1 = 8'h08;
  localparam logic [7:0] OFF_SYNTH_B0 = 8'h0C;
  localparam logic [7:0] OFF_CHAN_STEP = 8'h10;
  localparam logic [7:0] OFF_CHAN_INDEX = 8'h14;
  localparam logic [7:0] OFF_OSC_CFG = 8'h18;
  localparam logic [7:0] OFF_SYNTH_CFG2 = 8'h1C;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h20;
  localparam logic [7:0] OFF_CAL_RX = 8'h24;
  localparam logic [7:0] OFF_CAL_TX = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_CENTRE = 8'h30;
  // Field positions
  localparam int TOP_WORD_LSB = 0;
  localparam int TOP_BAND_BIT = 4;
  localparam int TOP_CP_LSB = 5;
  localparam int OSC_HALVE_BIT = 0;
  localparam int OSC_DOUBLE_BIT = 1;
  localparam int CFG2_SPLIT_BIT = 0;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CALDIS_BIT = 2;
  // Reset values
  localparam logic [7:0] RST_SYNTH_TOP = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_CHAN_STEP = 8'h00;
  // Channel step scale 2^15 against base scale 2^20, both in units of fxo/2^23
  localparam int CHAN_SHIFT = 8;
  // Requested radio modes
  localparam logic [1:0] MODE_READY = 2'h0;
  localparam logic [1:0] MODE_LOCK = 2'h1;
  localparam logic [1:0] MODE_RX = 2'h2;
  localparam logic [1:0] MODE_TX = 2'h3;
  // Timing, in ns, and derived cycle counts at the 100 MHz clock
  localparam int CLK_MHZ = 100;
  localparam int CAL_TIME_NS = 1000;
  localparam int LOCK_TIME_NS = 500;
  localparam int CAL_CYCLES = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  // Synthesizer sequencing states
  typedef enum logic [1:0] {SQ_IDLE, SQ_CAL, SQ_SETTLE, SQ_LOCKED} scc_seq_t;
endpackage

// ### tb/tb_scc_synth_ctrl.sv
// Self-checking testbench for the synthesizer channel control block
`timescale 1ns/1ps
module tb_scc_synth_ctrl;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h00000000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h00000000;
  logic [6:0] cal_result_i = 7'h00;
  logic hreadyout_o;
  logic hresp_o;
  logic [31:0] hrdata_o;
  logic [31:0] centre_freq_o;
  logic [6:0] cal_word_o;
  logic [2:0] charge_pump_current_sel_o;
  logic phase_detector_split_enable_o;
  logic band_divider_select_o;
  logic reference_halving_o;
  logic synth_locked_o;
  logic cal_busy_o;
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h987BB1B0;
  // Cycles of clock enable held low in the middle of a calibration
  int frz = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock: 100 MHz
  always #5 mclk_i = ~mclk_i;

  // Single slave, so its ready output is the bus ready
  scc_synth_ctrl #(.CAL_W(7)) uut (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .cal_result_i(cal_result_i), .centre_freq_o(centre_freq_o), .cal_word_o(cal_word_o),
    .charge_pump_current_sel_o(charge_pump_current_sel_o),
    .phase_detector_split_enable_o(phase_detector_split_enable_o),
    .band_divider_select_o(band_divider_select_o), .reference_halving_o(reference_halving_o),
    .synth_locked_o(synth_locked_o), .cal_busy_o(cal_busy_o));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and the single end of the run
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Bounded wait for ready; a hung slave ends the run as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 100);
    if (hreadyout_o !== 1'b1) begin
      chk("bus ready", 32'h00000001, 32'h00000000);
      test_done();
    end
  endtask

  // One single-word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h000000, a};
    hwrite_i <= w;
    wait_ready();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_ready();
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] got;
    bus(1'b0, a, 32'h00000000, got);
    chk(name, exp, got);
    chk("bus response", 32'h00000000, {31'h0, hresp_o});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference model of the centre word, in units of fxo/2^23
  function automatic logic [31:0] model_centre(int s, int b, int h, int st, int ix);
    int base;
    base = ((s << 2) >> b) >> h;
    return 32'(base + st * ix * 256);
  endfunction

  // Request a mode, count calibration cycles, wait for lock with a bound
  task automatic run_mode(input logic [1:0] m, input logic dis, input int exp_busy, input logic [6:0] exp_w);
    int busy;
    int n;
    busy = 0;
    wr(scc_pkg::OFF_MODE_CTRL, {29'h00000000, dis, m});
    for (n = 0; n < 2000; n++) begin
      @(posedge mclk_i);
      busy += (cal_busy_o === 1'b1) ? 1 : 0;
      // A frozen clock enable stretches the calibration by exactly the frozen cycles
      ce_i <= !(n >= 10 && n < 10 + frz);
      if (n > 4 && synth_locked_o === 1'b1) break;
    end
    if (n >= 2000) begin
      chk("lock reached", 32'h00000001, 32'h00000000);
      test_done();
    end
    chk("calibration cycles", 32'(exp_busy + frz), 32'(busy));
    chk("applied cal word", {25'h0000000, exp_w}, {25'h0000000, cal_word_o});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int s;
    int st;
    int ix;
    int cps[4] = '{2, 1, 3, 2};
    int spl[4] = '{0, 1, 0, 1};
    logic [6:0] r;
    logic [6:0] ra;
    logic [6:0] rb;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    // Reset values of every mapped location, then an unmapped one
    for (int a = 0; a <= 48; a += 4) begin
      rdc(8'(a), 32'h00000000, "reset value");
    end
    wr(8'h40, $random(seed));
    rdc(8'h40, 32'h00000000, "unmapped read");
    // Frequency words: all band and halving combinations, table charge pump codes
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 32'h0FFFFFFF : ($random(seed) & 32'h0FFFFFFF);
      st = (i == 0) ? 255 : ($random(seed) & 32'h000000FF);
      ix = (i == 0) ? 255 : ($random(seed) & 32'h000000FF);
      wr(scc_pkg::OFF_SYNTH_TOP, 32'((cps[i] << 5) | ((i & 1) << 4) | (s >> 24)));
      wr(scc_pkg::OFF_SYNTH_B2, 32'((s >> 16) & 255));
      wr(scc_pkg::OFF_SYNTH_B1, 32'((s >> 8) & 255));
      wr(scc_pkg::OFF_SYNTH_B0, 32'(s & 255));
      wr(scc_pkg::OFF_CHAN_STEP, 32'(st));
      wr(scc_pkg::OFF_CHAN_INDEX, 32'(ix));
      wr(scc_pkg::OFF_OSC_CFG, 32'(i >> 1));
      wr(scc_pkg::OFF_SYNTH_CFG2, 32'(spl[i]));
      rdc(scc_pkg::OFF_CENTRE, model_centre(s, i & 1, i >> 1, st, ix), "centre reg");
      chk("centre out", model_centre(s, i & 1, i >> 1, st, ix), centre_freq_o);
      chk("band out", 32'(i & 1), {31'h0, band_divider_select_o});
      chk("halving out", 32'(i >> 1), {31'h0, reference_halving_o});
      chk("cp out", 32'(cps[i]), {29'h0, charge_pump_current_sel_o});
      chk("split out", 32'(spl[i]), {31'h0, phase_detector_split_enable_o});
      // Hop by writing the channel index alone
      ix = $random(seed) & 32'h000000FF;
      wr(scc_pkg::OFF_CHAN_INDEX, 32'(ix));
      rdc(scc_pkg::OFF_CHAN_INDEX, 32'(ix), "index reg");
      chk("hop centre", model_centre(s, i & 1, i >> 1, st, ix), centre_freq_o);
    end
    // Calibration on lock needs ready to tx, tx to rx and ready to lock, result applied and stored
    wr(scc_pkg::OFF_OSC_CFG, 32'h00000000);
    r = 7'($random(seed));
    cal_result_i <= r;
    frz = 1 + ($random(seed) & 7);
    run_mode(scc_pkg::MODE_TX, 1'b0, scc_pkg::CAL_CYCLES, r);
    frz = 0;
    rdc(scc_pkg::OFF_CAL_TX, {25'h0, r}, "tx cal reg");
    r = 7'($random(seed));
    cal_result_i <= r;
    run_mode(scc_pkg::MODE_RX, 1'b0, scc_pkg::CAL_CYCLES, r);
    rdc(scc_pkg::OFF_CAL_RX, {25'h0, r}, "rx cal reg");
    wr(scc_pkg::OFF_MODE_CTRL, 32'h00000000);
    r = 7'($random(seed));
    cal_result_i <= r;
    run_mode(scc_pkg::MODE_LOCK, 1'b0, scc_pkg::CAL_CYCLES, r);
    rdc(scc_pkg::OFF_CAL_TX, {25'h0, r}, "lock cal reg");
    cal_result_i <= ~r;
    run_mode(scc_pkg::MODE_TX, 1'b0, 0, r);
    // Calibration disabled: stored words are used as they are
    wr(scc_pkg::OFF_MODE_CTRL, 32'h00000000);
    ra = 7'($random(seed));
    rb = 7'($random(seed));
    wr(scc_pkg::OFF_CAL_RX, {25'h0, ra});
    wr(scc_pkg::OFF_CAL_TX, {25'h0, rb});
    run_mode(scc_pkg::MODE_RX, 1'b1, 0, ra);
    run_mode(scc_pkg::MODE_TX, 1'b1, 0, rb);
    rdc(scc_pkg::OFF_STATUS, {26'h0, scc_pkg::MODE_TX, 2'(scc_pkg::SQ_LOCKED), 2'h2}, "status");
    // Double-rate reference halves the sequencer pace
    wr(scc_pkg::OFF_MODE_CTRL, 32'h00000000);
    wr(scc_pkg::OFF_OSC_CFG, 32'h00000002);
    r = 7'($random(seed));
    cal_result_i <= r;
    run_mode(scc_pkg::MODE_TX, 1'b0, 2 * scc_pkg::CAL_CYCLES, r);
    test_done();
  end
endmodule // tb_scc_synth_ctrl
